// ==== rtl/ecs_serializer.sv ====
`timescale 1ns/10ps
`include "ecs_map.svh"
// Behaviour
// - scrambled, balanced stream of 21+3 bits
// - four overhead bits, 28 per pixel
// - pixel clock 5 to 43 MHz
// - reference taken from input lane clock
// - outputs off until locked, then training words, then payloads
// - 21 bits recovered from three lanes
// - sideband sampled in pixel domain, appended
// - balance first, then control and clock
// - drive only when enabled, awake, locked
// - enable low keeps lock, outputs off
// - emphasis one bit after each transition
// - swing select picks normal or high swing
// - sideband bits at payload 21..23
// - lane 0 first slot lands at bit 6
// - sleep stops lock, outputs off
// - wake relocks and reinitialises
module ecs_serializer #(
    parameter int LOCK_PCLKS = `ECS_LOCK_PCLKS,
    parameter int INIT_WORDS = `ECS_INIT_WORDS
) (
    // reference clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // recovered input lanes, one slot word per pixel clock
    input  wire logic        INPUT_LANE_CLOCK,
    input  wire logic [6:0]  INPUT_LANE_0,
    input  wire logic [6:0]  INPUT_LANE_1,
    input  wire logic [6:0]  INPUT_LANE_2,
    // slow level inputs
    input  wire logic [2:0]  SIDEBAND_INPUTS,
    // control pins
    input  wire logic        LINE_OUTPUT_ENABLE,
    input  wire logic        SLEEP_REQUEST_N,
    input  wire logic        SWING_SELECT,
    input  wire logic        EMPHASIS_ENABLE,
    // serial line driver side
    output logic [27:0]      SERIAL_WORD,
    output logic [27:0]      EMPHASIS_MASK,
    output logic             SERIAL_OE_N,
    output logic             SWING_HIGH,
    // status
    output logic             PLL_LOCKED
);

    localparam int SILENCE = `ECS_SILENCE_CYCLES;
    localparam logic [7:0] LOCK_N = LOCK_PCLKS[7:0];
    localparam logic [7:0] INIT_N = INIT_WORDS[7:0];
    localparam logic [7:0] SILENCE_N = SILENCE[7:0];

    // control bit places in the synchroniser
    localparam int C_ENABLE = 0;
    localparam int C_AWAKE  = 1;
    localparam int C_SWING  = 2;
    localparam int C_EMPH   = 3;

    // refuse counts and geometry the counters and framing cannot serve
    if (LOCK_PCLKS < 1 || LOCK_PCLKS > 255) begin : g_bad_lock
        $error("LOCK_PCLKS must lie in 1..255");
    end
    if (INIT_WORDS < 1 || INIT_WORDS > 255) begin : g_bad_init
        $error("INIT_WORDS must lie in 1..255");
    end
    if (SILENCE > 250) begin : g_bad_silence
        $error("silence timeout does not fit the gap counter");
    end
    if (`ECS_LANES * `ECS_LANE_SLOTS != `ECS_RECOVERED_BITS) begin : g_bad_lanes
        $error("lane geometry does not give the recovered bit count");
    end
    if (`ECS_PAYLOAD_BITS + 4 != `ECS_WORD_BITS) begin : g_bad_word
        $error("word must carry four overhead bits beyond the payload");
    end

    // lane k slot s to payload bit; slot 0 of lane 0 lands at bit 6
    function automatic logic [20:0] map_lanes(input logic [20:0] raw);
        logic [20:0] p;
        int          pos;
        p = '0;
        for (int k = 0; k < `ECS_LANES; k++) begin
            for (int s = 0; s < `ECS_LANE_SLOTS; s++) begin
                pos = k * `ECS_LANE_SLOTS
                      + ((s + `ECS_LANE0_FIRST_POS) % `ECS_LANE_SLOTS);
                p[pos] = raw[k * `ECS_LANE_SLOTS + s];
            end
        end
        return p;
    endfunction : map_lanes

    // additive scrambler x^15 + x^14 + 1, 24 steps per word
    function automatic logic [38:0] lfsr_run(input logic [14:0] st);
        logic [14:0] s;
        logic [23:0] key;
        s = st;
        key = '0;
        for (int i = 0; i < `ECS_PAYLOAD_BITS; i++) begin
            key[i] = s[14] ^ s[13];
            s = {s[13:0], key[i]};
        end
        return {s, key};
    endfunction : lfsr_run

    function automatic logic signed [7:0] disparity(input logic [23:0] d);
        logic [7:0] ones;
        ones = '0;
        for (int i = 0; i < `ECS_PAYLOAD_BITS; i++)
            ones = ones + {7'h00, d[i]};
        return $signed({ones[6:0], 1'b0}) - 8'sd24;
    endfunction : disparity

    // invert when the word would push disparity further the same way
    function automatic logic wants_invert(input logic signed [7:0] rd,
                                          input logic signed [7:0] dw);
        return (rd > 8'sd0 && dw > 8'sd0) || (rd < 8'sd0 && dw < 8'sd0);
    endfunction : wants_invert

    // running disparity after a payload word, flag and control bit included
    function automatic logic signed [7:0] next_rd(input logic signed [7:0] rd,
                                                  input logic signed [7:0] dw,
                                                  input logic              f);
        logic signed [7:0] flag;
        flag = f ? 8'sd1 : -8'sd1;
        return rd + dw + flag + 8'sd1;
    endfunction : next_rd

    // clock high, invert flag, data, control, clock low
    function automatic logic [27:0] frame_word(input logic        f,
                                               input logic [23:0] d,
                                               input logic        c);
        logic [27:0] w;
        w                                  = '0;
        w[`ECS_W_CLK_HI]                   = 1'b1;
        w[`ECS_W_INVERT]                   = f;
        w[`ECS_W_DATA_MSB:`ECS_W_DATA_LSB] = d;
        w[`ECS_W_CTRL]                     = c;
        w[`ECS_W_CLK_LO]                   = 1'b0;
        return w;
    endfunction : frame_word

    // first bit after each change of level, msb sent first
    function automatic logic [27:0] emph_marks(input logic [27:0] w,
                                               input logic        last,
                                               input logic        en);
        logic [27:0] m;
        logic        pb;
        pb = last;
        for (int i = `ECS_WORD_BITS - 1; i >= 0; i--) begin
            m[i] = en && (w[i] != pb);
            pb = w[i];
        end
        return m;
    endfunction : emph_marks

    // line driver on only when enabled, awake, locked and past idle
    function automatic logic may_drive(input logic [3:0]         ctl,
                                       input logic               lock,
                                       input ecs_pkg::ecs_link_e st);
        return ctl[C_ENABLE] && ctl[C_AWAKE] && lock && st != ecs_pkg::LK_IDLE;
    endfunction : may_drive

    // reference clock domain
    ecs_pkg::ecs_sys_s sys_r;
    ecs_pkg::ecs_sys_s sys_nxt;
    ecs_pkg::ecs_lnk_s lnk_r;
    ecs_pkg::ecs_lnk_s lnk_nxt;
    logic              pclk_edge;

    always_comb begin
        sys_nxt        = sys_r;
        sys_nxt.tog_s1 = lnk_r.tog;
        sys_nxt.tog_s2 = sys_r.tog_s1;
        sys_nxt.tog_s3 = sys_r.tog_s2;
        sys_nxt.slp_s1 = SLEEP_REQUEST_N;
        sys_nxt.slp_s2 = sys_r.slp_s1;
        pclk_edge      = sys_r.tog_s2 ^ sys_r.tog_s3;
        if (!sys_r.slp_s2) begin
            // lock stopped while asleep
            sys_nxt.gap    = '0;
            sys_nxt.edges  = '0;
            sys_nxt.locked = 1'b0;
        end else if (pclk_edge) begin
            // lock builds on consecutive pixel clocks of the input lanes
            sys_nxt.gap = '0;
            if (sys_r.edges < LOCK_N)
                sys_nxt.edges = sys_r.edges + 8'h01;
            else
                sys_nxt.locked = 1'b1;
        end else begin
            // a pixel period beyond the slowest rate drops lock
            if (sys_r.gap < SILENCE_N)
                sys_nxt.gap = sys_r.gap + 8'h01;
            else begin
                sys_nxt.edges  = '0;
                sys_nxt.locked = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sys_r <= '0;
        end else begin
            sys_r <= sys_nxt;
        end
    end

    assign PLL_LOCKED = sys_r.locked;

    // pixel clock domain
    logic [23:0]       payload;
    logic [23:0]       scr;
    logic [23:0]       data;
    logic [38:0]       run;
    logic signed [7:0] disp;
    logic              inv;
    logic              ctrl;
    logic              drive;
    logic [27:0]       word;

    always_comb begin
        lnk_nxt        = lnk_r;
        lnk_nxt.lane_a = {INPUT_LANE_2, INPUT_LANE_1, INPUT_LANE_0};
        lnk_nxt.lane_b = lnk_r.lane_a;
        lnk_nxt.sb_a   = SIDEBAND_INPUTS;
        lnk_nxt.sb_b   = lnk_r.sb_a;
        lnk_nxt.ctl_a  = {EMPHASIS_ENABLE, SWING_SELECT, SLEEP_REQUEST_N,
                          LINE_OUTPUT_ENABLE};
        lnk_nxt.ctl_b  = lnk_r.ctl_a;
        lnk_nxt.lock_a = sys_r.locked;
        lnk_nxt.lock_b = lnk_r.lock_a;
        lnk_nxt.tog    = ~lnk_r.tog;

        // 21 recovered bits plus sideband in the same pixel period
        payload = {lnk_r.sb_b, map_lanes(lnk_r.lane_b)};
        run     = lfsr_run(lnk_r.lfsr);
        scr     = payload ^ run[23:0];
        data    = `ECS_TRAIN_DATA;
        ctrl    = 1'b0;
        inv     = 1'b0;
        disp    = 8'sd0;

        unique case (lnk_r.state)
            ecs_pkg::LK_IDLE: begin
                lnk_nxt.lfsr     = `ECS_LFSR_SEED;
                lnk_nxt.rd       = 8'sd0;
                lnk_nxt.init_cnt = '0;
                if (lnk_r.lock_b)
                    lnk_nxt.state = ecs_pkg::LK_INIT;
            end
            ecs_pkg::LK_INIT: begin
                // training words let the far end lock before payloads
                lnk_nxt.lfsr = `ECS_LFSR_SEED;
                if (lnk_r.init_cnt == INIT_N - 8'h01)
                    lnk_nxt.state = ecs_pkg::LK_RUN;
                else
                    lnk_nxt.init_cnt = lnk_r.init_cnt + 8'h01;
            end
            ecs_pkg::LK_RUN: begin
                lnk_nxt.lfsr = run[38:24];
                ctrl         = 1'b1;
                disp         = disparity(scr);
                // balance the scrambled payload against running disparity
                inv = wants_invert(lnk_r.rd, disp);
                data = inv ? ~scr : scr;
                disp = inv ? -disp : disp;
            end
        endcase
        if (!lnk_r.lock_b)
            lnk_nxt.state = ecs_pkg::LK_IDLE;

        // overhead added only after balancing
        word = frame_word(inv, data, ctrl);
        if (lnk_r.state == ecs_pkg::LK_RUN)
            lnk_nxt.rd = next_rd(lnk_r.rd, disp, inv);

        // emphasis marks only the first bit after each change
        lnk_nxt.emph = emph_marks(word, lnk_r.last_bit, lnk_r.ctl_b[C_EMPH]);
        lnk_nxt.word     = word;
        lnk_nxt.last_bit = word[`ECS_W_CLK_LO];

        drive = may_drive(lnk_r.ctl_b, lnk_r.lock_b, lnk_r.state);
        lnk_nxt.oe_n  = ~drive;
        lnk_nxt.swing = lnk_r.ctl_b[C_SWING];
        if (!drive)
            lnk_nxt.emph = '0;
    end

    always_ff @(posedge INPUT_LANE_CLOCK or negedge NRST) begin
        if (!NRST) begin
            lnk_r          <= '0;
            lnk_r.state    <= ecs_pkg::LK_IDLE;
            lnk_r.lfsr     <= `ECS_LFSR_SEED;
            lnk_r.oe_n     <= 1'b1;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // a stopped pixel clock cannot release the driver, so lock loss does
    assign SERIAL_OE_N   = lnk_r.oe_n | ~sys_r.locked;
    assign SERIAL_WORD   = lnk_r.word;
    assign EMPHASIS_MASK = lnk_r.emph;
    assign SWING_HIGH    = lnk_r.swing;

endmodule : ecs_serializer

// ==== pkg/ecs_map.svh ====
`ifndef ECS_MAP_SVH
`define ECS_MAP_SVH

// clock and pixel clock figures
`define ECS_CLK_PERIOD_NS       10
`define ECS_PCLK_MIN_MHZ        5
`define ECS_PCLK_MAX_MHZ        43
`define ECS_PCLK_MAX_PERIOD_NS  (1000 / `ECS_PCLK_MIN_MHZ)
`define ECS_SYNC_MARGIN         4
`define ECS_SILENCE_CYCLES      (((`ECS_PCLK_MAX_PERIOD_NS + `ECS_CLK_PERIOD_NS - 1) \
                                 / `ECS_CLK_PERIOD_NS) + `ECS_SYNC_MARGIN)
`define ECS_LOCK_PCLKS          64
`define ECS_INIT_WORDS          16

// payload and lane geometry
`define ECS_LANES               3
`define ECS_LANE_SLOTS          7
`define ECS_RECOVERED_BITS      21
`define ECS_SIDEBAND_BITS       3
`define ECS_PAYLOAD_BITS        24
`define ECS_WORD_BITS           28
`define ECS_SIDEBAND_LSB        21
`define ECS_LANE0_FIRST_POS     6

// serial word field positions, sent msb first
`define ECS_W_CLK_HI            27
`define ECS_W_INVERT            26
`define ECS_W_DATA_MSB          25
`define ECS_W_DATA_LSB          2
`define ECS_W_CTRL              1
`define ECS_W_CLK_LO            0

// reset values and patterns
`define ECS_LFSR_SEED           15'h7fff
`define ECS_TRAIN_DATA          24'haa_aaaa

`endif

// ==== pkg/ecs_pkg.sv ====
package ecs_pkg;

    typedef enum logic [1:0] {LK_IDLE, LK_INIT, LK_RUN} ecs_link_e;

    // reference clock side: pixel clock activity and lock
    typedef struct packed {
        logic       tog_s1;
        logic       tog_s2;
        logic       tog_s3;
        logic       slp_s1;
        logic       slp_s2;
        logic [7:0] gap;
        logic [7:0] edges;
        logic       locked;
    } ecs_sys_s;

    // pixel clock side: capture, coding and line control
    typedef struct packed {
        logic [20:0]       lane_a;
        logic [20:0]       lane_b;
        logic [2:0]        sb_a;
        logic [2:0]        sb_b;
        logic [3:0]        ctl_a;
        logic [3:0]        ctl_b;
        logic              lock_a;
        logic              lock_b;
        logic              tog;
        ecs_link_e         state;
        logic [7:0]        init_cnt;
        logic [14:0]       lfsr;
        logic signed [7:0] rd;
        logic [27:0]       word;
        logic [27:0]       emph;
        logic              last_bit;
        logic              oe_n;
        logic              swing;
    } ecs_lnk_s;

endpackage : ecs_pkg

// ==== tb/ecs_serializer_properties.sv ====
`timescale 1ns/10ps
module ecs_serializer_checker (
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        INPUT_LANE_CLOCK,
    input wire logic        LINE_OUTPUT_ENABLE,
    input wire logic        SLEEP_REQUEST_N,
    input wire logic        SWING_SELECT,
    input wire logic        EMPHASIS_ENABLE,
    input wire logic [27:0] SERIAL_WORD,
    input wire logic [27:0] EMPHASIS_MASK,
    input wire logic        SERIAL_OE_N,
    input wire logic        SWING_HIGH,
    input wire logic        PLL_LOCKED
);
    // reference cycles since the pixel clock last moved
    logic       pclk_d_r;
    logic [7:0] quiet_r;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pclk_d_r <= 1'b0;
            quiet_r  <= 8'h00;
        end else begin
            pclk_d_r <= INPUT_LANE_CLOCK;
            if (pclk_d_r != INPUT_LANE_CLOCK)
                quiet_r <= 8'h00;
            else if (quiet_r != 8'hff)
                quiet_r <= quiet_r + 8'h01;
        end
    end
    property p_oe_lock;
        @(posedge CLK) disable iff (!NRST) !PLL_LOCKED |-> SERIAL_OE_N;
    endproperty
    a_oe_lock: assert property (p_oe_lock) else $error("driving while unlocked");
    property p_quiet;
        @(posedge CLK) disable iff (!NRST) quiet_r > 8'h1e |-> !PLL_LOCKED;
    endproperty
    a_quiet: assert property (p_quiet) else $error("locked without pixel clock");
    property p_sleep;
        @(posedge CLK) disable iff (!NRST)
            $fell(SLEEP_REQUEST_N) |-> ##[0:4] (!PLL_LOCKED && SERIAL_OE_N);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not stop line");
    property p_frame;
        @(posedge INPUT_LANE_CLOCK) disable iff (!NRST)
            !SERIAL_OE_N |-> SERIAL_WORD[27] && !SERIAL_WORD[0];
    endproperty
    a_frame: assert property (p_frame) else $error("embedded clock bits wrong");
    property p_disable;
        @(posedge INPUT_LANE_CLOCK) disable iff (!NRST) !LINE_OUTPUT_ENABLE [*3] |=> SERIAL_OE_N;
    endproperty
    a_disable: assert property (p_disable) else $error("driving while disabled");
    property p_emph;
        @(posedge INPUT_LANE_CLOCK) disable iff (!NRST)
            !SERIAL_OE_N && !$past(SERIAL_OE_N) && $past(EMPHASIS_ENABLE, 3)
            |-> EMPHASIS_MASK == {SERIAL_WORD[27] ^ $past(SERIAL_WORD[0]),
                                  SERIAL_WORD[26:0] ^ SERIAL_WORD[27:1]};
    endproperty
    a_emph: assert property (p_emph) else $error("emphasis not on transitions");
    property p_emph_off;
        @(posedge INPUT_LANE_CLOCK) disable iff (!NRST)
            !$past(EMPHASIS_ENABLE, 3) |-> EMPHASIS_MASK == 28'h000_0000;
    endproperty
    a_emph_off: assert property (p_emph_off) else $error("emphasis while off");
    property p_swing;
        @(posedge INPUT_LANE_CLOCK) disable iff (!NRST)
            (SWING_SELECT [*4] |=> SWING_HIGH) and (!SWING_SELECT [*4] |=> !SWING_HIGH);
    endproperty
    a_swing: assert property (p_swing) else $error("swing level wrong");
endmodule : ecs_serializer_checker

bind ecs_serializer ecs_serializer_checker u_ecs_serializer_checker (
    .CLK(CLK), .NRST(NRST), .INPUT_LANE_CLOCK(INPUT_LANE_CLOCK),
    .LINE_OUTPUT_ENABLE(LINE_OUTPUT_ENABLE), .SLEEP_REQUEST_N(SLEEP_REQUEST_N),
    .SWING_SELECT(SWING_SELECT), .EMPHASIS_ENABLE(EMPHASIS_ENABLE),
    .SERIAL_WORD(SERIAL_WORD), .EMPHASIS_MASK(EMPHASIS_MASK), .SERIAL_OE_N(SERIAL_OE_N),
    .SWING_HIGH(SWING_HIGH), .PLL_LOCKED(PLL_LOCKED)
);

// ==== tb/ecs_far_end.sv ====
`timescale 1ns/10ps
`include "ecs_map.svh"
module ecs_far_end (
    input  wire logic        pclk,
    input  wire logic        nrst,
    input  wire logic [27:0] word,
    input  wire logic        oe_n,
    output logic [23:0]      payload,
    output logic             valid,
    output logic             lock
);
    logic [14:0] s;
    logic [23:0] d;
    logic        k;
    always @(posedge pclk or negedge nrst) begin
        valid = 1'b0;
        if (!nrst || oe_n || !word[27] || word[0]) begin
            lock = 1'b0;
        end else if (!word[1]) begin
            s    = `ECS_LFSR_SEED;
            lock = 1'b1;
        end else if (lock) begin
            d = word[25:2] ^ {24{word[26]}};
            for (int i = 0; i < 24; i++) begin
                k    = s[14] ^ s[13];
                s    = {s[13:0], k};
                d[i] = d[i] ^ k;
            end
            valid = 1'b1;
        end
        payload = lock ? d : 'z;
    end
endmodule : ecs_far_end

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    logic        clk, nrst, pclk, run_pclk, lane_oe, sleep_n, swing, emph;
    logic        oe_n, swing_hi, locked, far_valid, far_lock, synced;
    logic [6:0]  lane [3];
    logic [2:0]  sb;
    logic [27:0] word, mask;
    logic [23:0] far_pl, exp_pl;
    logic [23:0] notes [$];
    int          mismatches, checked, cycles, words;
    ecs_serializer #(.LOCK_PCLKS(16), .INIT_WORDS(4)) u_ecs_serializer (
        .CLK(clk), .NRST(nrst), .INPUT_LANE_CLOCK(pclk), .INPUT_LANE_0(lane[0]),
        .INPUT_LANE_1(lane[1]), .INPUT_LANE_2(lane[2]), .SIDEBAND_INPUTS(sb),
        .LINE_OUTPUT_ENABLE(lane_oe), .SLEEP_REQUEST_N(sleep_n), .SWING_SELECT(swing),
        .EMPHASIS_ENABLE(emph), .SERIAL_WORD(word), .EMPHASIS_MASK(mask),
        .SERIAL_OE_N(oe_n), .SWING_HIGH(swing_hi), .PLL_LOCKED(locked));
    ecs_far_end u_ecs_far_end (.pclk(pclk), .nrst(nrst), .word(word), .oe_n(oe_n),
        .payload(far_pl), .valid(far_valid), .lock(far_lock));
    always #5 clk = ~clk;
    initial begin
        #13;
        forever #40 if (run_pclk) pclk = ~pclk;
    end
    task automatic cmp(input string what, input logic [27:0] exp, input logic [27:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic cmp_payload(input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected payload: expected %h, seen %h", exp, got);
        end
    endtask : cmp_payload
    task automatic print_verdict();
        if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic pixels(input int n);
        repeat (n) @(negedge pclk);
    endtask : pixels
    task automatic wait_far();
        int n;
        n = 0;
        pixels(2);
        while (!far_lock && n < 400) begin
            @(negedge pclk);
            n++;
        end
        pixels(40);
        cmp("synced", 28'h000_0001, {27'h0, synced});
    endtask : wait_far
    // random lane words, slow sideband, expected payload noted
    always @(negedge pclk) begin
        if (nrst) begin
            for (int k = 0; k < 3; k++) lane[k] = 7'($urandom);
            if (words % 8 == 0) sb = 3'($urandom);
            words++;
            for (int k = 0; k < 3; k++)
                for (int s = 0; s < 7; s++)
                    exp_pl[7 * k + (s + 6) % 7] = lane[k][s];
            exp_pl[23:21] = sb;
            notes.push_back(exp_pl);
            if (!synced && notes.size() > 8) void'(notes.pop_front());
        end
    end
    // far end output against oldest note; first word after lock aligns the queue
    always @(negedge pclk) begin
        if (!far_lock) synced = 1'b0;
        if (far_valid) begin
            while (!synced && notes.size() > 0 && notes[0] !== far_pl) void'(notes.pop_front());
            if (notes.size() > 0) begin
                synced = 1'b1;
                cmp_payload(notes.pop_front(), far_pl);
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        clk = 0; pclk = 0; run_pclk = 1; nrst = 0; lane_oe = 1; sleep_n = 1;
        swing = 0; emph = 1; sb = 0; synced = 0; lane = '{default: 7'h00};
        void'($urandom(32'h24b3));
        repeat (4) @(negedge clk);
        nrst = 1;
        wait_far();
        cmp("locked", 28'h000_0001, {27'h0, locked});
        swing = 1;
        emph = 0;
        pixels(6);
        cmp("swing", 28'h000_0001, {27'h0, swing_hi});
        cmp("mask", 28'h000_0000, mask);
        emph = 1;
        lane_oe = 0;
        pixels(5);
        cmp("oe_n", 28'h000_0001, {27'h0, oe_n});
        cmp("locked", 28'h000_0001, {27'h0, locked});
        lane_oe = 1;
        pixels(5);
        cmp("oe_n", 28'h000_0000, {27'h0, oe_n});
        sleep_n = 0;
        pixels(2);
        cmp("locked", 28'h000_0000, {27'h0, locked});
        cmp("oe_n", 28'h000_0001, {27'h0, oe_n});
        sleep_n = 1;
        wait_far();
        run_pclk = 0;
        repeat (40) @(negedge clk);
        cmp("locked", 28'h000_0000, {27'h0, locked});
        run_pclk = 1;
        wait_far();
        print_verdict();
    end
endmodule : testbench
